// ---- logic/bsr_tap.v ----
`include "bsr_map.vh"

// Function
// - two data registers, boundary chain and bypass, chosen by instruction.
// - bypass places exactly one flip-flop stage between tdi and tdo.
// - boundary chain is 118 cells, indices 0 to 117.
// - cell 0 shifts out first; cell 117 sits next to tdi.
// - control cells active high; 1 drives the pin, 0 floats it.
// - tx streams use control even, output odd, cells 0-15 and 102-117.
// - cell 16 drive-enable input, 17/18 control channel, 19 ack output.
// - sixteen bus pins get control, output, input cells, 20 to 67.
// - input cells 68-101 carry strobes, address, straps, frame, rx 15-0.
// - codes 0-1 extest, 2-5 sample/preload, 6-7 bypass.
// - tms and tdi are sampled at rising test clock edges.
// - tdo changes at falling test clock edges while shifting.
// - tdo floats whenever no register is shifting.
module bsr_tap (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        arst_n_i,
    // test port pins
    input  wire        tck_i,
    input  wire        tms_i,
    input  wire        tdi_i,
    input  wire        trst_n_i,
    output reg         tdo_o,
    output reg         tdo_oe_o,
    // functional side, from core
    input  wire [15:0] core_tx_i,
    input  wire [15:0] core_tx_oe_i,
    input  wire        core_chan_ctl_i,
    input  wire        core_chan_ctl_oe_i,
    input  wire        core_ack_i,
    input  wire [15:0] core_bus_i,
    input  wire [15:0] core_bus_oe_i,
    // pin values seen at the input buffers
    input  wire [15:0] pin_bus_i,
    input  wire        output_drive_enable_pin_i,
    input  wire [17:0] pin_ctl_i,
    input  wire [15:0] pin_rx_i,
    // driven pin side
    output wire [15:0] pin_tx_o,
    output wire [15:0] pin_tx_oe_o,
    output wire        control_channel_pin_o,
    output wire        control_channel_pin_oe_o,
    output wire        data_ack_pin_o,
    output wire [15:0] pin_bus_o,
    output wire [15:0] pin_bus_oe_o,
    output wire        extest_o
);
    localparam N = `BSR_LEN;

    // ======================================================
    // reset release and input sampling
    reg  [1:0] rst_sh_r;
    wire       rst_n = rst_sh_r[1];
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) rst_sh_r <= 2'b00;
        else rst_sh_r <= {rst_sh_r[0], 1'b1};
    end

    wire [3:0] tp_s;
    bsr_sync #(.W(4)) u_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({trst_n_i, tdi_i, tms_i, tck_i}),
        .q_o     (tp_s)
    );
    reg  tck_d_r;
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) tck_d_r <= 1'b0;
        else tck_d_r <= tp_s[0];
    end
    wire tck_rise = tp_s[0] & ~tck_d_r;
    wire tck_fall = ~tp_s[0] & tck_d_r;
    wire tms_s    = tp_s[1];
    wire tdi_s    = tp_s[2];
    wire trst_ok  = tp_s[3];

    // pin images for capture cross into the core clock as well
    wire [15:0] pin_bus_s;
    wire [15:0] pin_rx_s;
    wire [17:0] pin_ctl_s;
    wire        drv_en_s;
    bsr_sync #(.W(51)) u_pin_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({output_drive_enable_pin_i, pin_ctl_i, pin_rx_i,
                   pin_bus_i}),
        .q_o     ({drv_en_s, pin_ctl_s, pin_rx_s, pin_bus_s})
    );

    // ======================================================
    // tap controller, advances at sampled rising edges
    reg [3:0] st_r;
    reg [3:0] st_nxt;
    always @* begin
        case (st_r)
            `BSR_ST_RESET:  st_nxt = tms_s ? `BSR_ST_RESET  : `BSR_ST_IDLE;
            `BSR_ST_IDLE:   st_nxt = tms_s ? `BSR_ST_SEL_DR : `BSR_ST_IDLE;
            `BSR_ST_SEL_DR: st_nxt = tms_s ? `BSR_ST_SEL_IR : `BSR_ST_CAP_DR;
            `BSR_ST_CAP_DR: st_nxt = tms_s ? `BSR_ST_EX1_DR : `BSR_ST_SH_DR;
            `BSR_ST_SH_DR:  st_nxt = tms_s ? `BSR_ST_EX1_DR : `BSR_ST_SH_DR;
            `BSR_ST_EX1_DR: st_nxt = tms_s ? `BSR_ST_UPD_DR : `BSR_ST_PAU_DR;
            `BSR_ST_PAU_DR: st_nxt = tms_s ? `BSR_ST_EX2_DR : `BSR_ST_PAU_DR;
            `BSR_ST_EX2_DR: st_nxt = tms_s ? `BSR_ST_UPD_DR : `BSR_ST_SH_DR;
            `BSR_ST_UPD_DR: st_nxt = tms_s ? `BSR_ST_SEL_DR : `BSR_ST_IDLE;
            `BSR_ST_SEL_IR: st_nxt = tms_s ? `BSR_ST_RESET  : `BSR_ST_CAP_IR;
            `BSR_ST_CAP_IR: st_nxt = tms_s ? `BSR_ST_EX1_IR : `BSR_ST_SH_IR;
            `BSR_ST_SH_IR:  st_nxt = tms_s ? `BSR_ST_EX1_IR : `BSR_ST_SH_IR;
            `BSR_ST_EX1_IR: st_nxt = tms_s ? `BSR_ST_UPD_IR : `BSR_ST_PAU_IR;
            `BSR_ST_PAU_IR: st_nxt = tms_s ? `BSR_ST_EX2_IR : `BSR_ST_PAU_IR;
            `BSR_ST_EX2_IR: st_nxt = tms_s ? `BSR_ST_UPD_IR : `BSR_ST_SH_IR;
            `BSR_ST_UPD_IR: st_nxt = tms_s ? `BSR_ST_SEL_DR : `BSR_ST_IDLE;
            default:        st_nxt = `BSR_ST_RESET;
        endcase
    end

    // ======================================================
    // instruction register and decode
    reg  [`BSR_IR_W-1:0] ir_sh_r;
    reg  [`BSR_IR_W-1:0] ir_r;
    wire sel_byp  = (ir_r >= `BSR_IR_BYP_MIN);
    wire is_ext   = (ir_r <= `BSR_IR_EXT_MAX);
    assign extest_o = is_ext;

    // ======================================================
    // boundary chain: capture image from pins and core
    wire [N-1:0] cap;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_tx
            // stream 7-g low half, 15-g high half
            assign cap[`BSR_TXLO_BASE + 2*g]     = core_tx_oe_i[7-g];
            assign cap[`BSR_TXLO_BASE + 2*g + 1] = core_tx_i[7-g];
            assign cap[`BSR_TXHI_BASE + 2*g]     = core_tx_oe_i[15-g];
            assign cap[`BSR_TXHI_BASE + 2*g + 1] = core_tx_i[15-g];
        end
        for (g = 0; g < 16; g = g + 1) begin : g_bus
            // bit 15 first; control, output, input
            assign cap[`BSR_BUS_BASE + 3*g]     = core_bus_oe_i[15-g];
            assign cap[`BSR_BUS_BASE + 3*g + 1] = core_bus_i[15-g];
            assign cap[`BSR_BUS_BASE + 3*g + 2] = pin_bus_s[15-g];
            assign cap[`BSR_RX_BASE + g]        = pin_rx_s[15-g];
        end
        for (g = 0; g < 18; g = g + 1) begin : g_ctl
            // pin_ctl_i[17] is the bus type select, down to frame
            assign cap[`BSR_STRAP_BASE + g]     = pin_ctl_s[17-g];
        end
    endgenerate
    assign cap[`BSR_DRV_EN_IN] = drv_en_s;
    assign cap[`BSR_CHAN_CTL]  = core_chan_ctl_oe_i;
    assign cap[`BSR_CHAN_OUT]  = core_chan_ctl_i;
    assign cap[`BSR_ACK_OUT]   = core_ack_i;

    // ======================================================
    // shift, capture and update at rising test clock
    reg [N-1:0] bs_sh_r;
    reg [N-1:0] bs_up_r;
    reg         byp_r;
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= `BSR_ST_RESET;
            ir_sh_r <= {`BSR_IR_W{1'b0}};
            ir_r    <= `BSR_IR_RST;
            bs_sh_r <= {N{1'b0}};
            bs_up_r <= {N{1'b0}};
            byp_r   <= 1'b0;
        end else if (!trst_ok) begin
            st_r    <= `BSR_ST_RESET;
            ir_r    <= `BSR_IR_RST;
        end else if (tck_rise) begin
            st_r <= st_nxt;
            case (st_r)
                `BSR_ST_RESET:  ir_r    <= `BSR_IR_RST;
                `BSR_ST_CAP_IR: ir_sh_r <= `BSR_IR_CAPT;
                `BSR_ST_SH_IR:  ir_sh_r <= {tdi_s, ir_sh_r[`BSR_IR_W-1:1]};
                `BSR_ST_UPD_IR: ir_r    <= ir_sh_r;
                `BSR_ST_CAP_DR: begin
                    byp_r <= 1'b0;
                    if (!sel_byp) bs_sh_r <= cap;
                end
                `BSR_ST_SH_DR: begin
                    if (sel_byp) byp_r <= tdi_s;
                    else bs_sh_r <= {tdi_s, bs_sh_r[N-1:1]};
                end
                `BSR_ST_UPD_DR: if (!sel_byp) bs_up_r <= bs_sh_r;
                default: ;
            endcase
        end
    end

    // ======================================================
    // tdo: falling test clock, floats when not shifting
    wire shifting = (st_r == `BSR_ST_SH_DR) || (st_r == `BSR_ST_SH_IR);
    wire so = (st_r == `BSR_ST_SH_IR) ? ir_sh_r[0] :
              (sel_byp ? byp_r : bs_sh_r[0]);
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o    <= shifting ? so : 1'b0;
            tdo_oe_o <= shifting;
        end
    end

    // ======================================================
    // pin muxing: extest drives from update cells, else core
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_txo
            assign pin_tx_oe_o[7-g]  = is_ext ?
                bs_up_r[`BSR_TXLO_BASE + 2*g] : core_tx_oe_i[7-g];
            assign pin_tx_o[7-g]     = is_ext ?
                bs_up_r[`BSR_TXLO_BASE + 2*g + 1] : core_tx_i[7-g];
            assign pin_tx_oe_o[15-g] = is_ext ?
                bs_up_r[`BSR_TXHI_BASE + 2*g] : core_tx_oe_i[15-g];
            assign pin_tx_o[15-g]    = is_ext ?
                bs_up_r[`BSR_TXHI_BASE + 2*g + 1] : core_tx_i[15-g];
        end
        for (g = 0; g < 16; g = g + 1) begin : g_buso
            assign pin_bus_oe_o[15-g] = is_ext ?
                bs_up_r[`BSR_BUS_BASE + 3*g] : core_bus_oe_i[15-g];
            assign pin_bus_o[15-g]    = is_ext ?
                bs_up_r[`BSR_BUS_BASE + 3*g + 1] : core_bus_i[15-g];
        end
    endgenerate
    assign control_channel_pin_oe_o = is_ext ?
        bs_up_r[`BSR_CHAN_CTL] : core_chan_ctl_oe_i;
    assign control_channel_pin_o    = is_ext ?
        bs_up_r[`BSR_CHAN_OUT] : core_chan_ctl_i;
    assign data_ack_pin_o = is_ext ? bs_up_r[`BSR_ACK_OUT] : core_ack_i;
endmodule

// ---- inc/bsr_map.vh ----
`ifndef BSR_MAP_VH
`define BSR_MAP_VH
// chain geometry
`define BSR_LEN          118
`define BSR_TXLO_BASE    0
`define BSR_DRV_EN_IN    16
`define BSR_CHAN_CTL     17
`define BSR_CHAN_OUT     18
`define BSR_ACK_OUT      19
`define BSR_BUS_BASE     20
`define BSR_STRAP_BASE   68
`define BSR_RX_BASE      86
`define BSR_TXHI_BASE    102
// instruction codes
`define BSR_IR_W         3
`define BSR_IR_RST       3'h7
`define BSR_IR_EXT_MAX   3'h1
`define BSR_IR_BYP_MIN   3'h6
// tap states, then the ir capture value
`define BSR_ST_RESET     4'h0
`define BSR_ST_IDLE      4'h1
`define BSR_ST_SEL_DR    4'h2
`define BSR_ST_CAP_DR    4'h3
`define BSR_ST_SH_DR     4'h4
`define BSR_ST_EX1_DR    4'h5
`define BSR_ST_PAU_DR    4'h6
`define BSR_ST_EX2_DR    4'h7
`define BSR_ST_UPD_DR    4'h8
`define BSR_ST_SEL_IR    4'h9
`define BSR_ST_CAP_IR    4'ha
`define BSR_ST_SH_IR     4'hb
`define BSR_ST_EX1_IR    4'hc
`define BSR_ST_PAU_IR    4'hd
`define BSR_ST_EX2_IR    4'he
`define BSR_ST_UPD_IR    4'hf
`define BSR_IR_CAPT      3'h1
`endif

// ---- logic/bsr_sync.v ----
// two-stage synchroniser, one per bit
module bsr_sync #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= d_i[g];
                    s2_r <= s1_r;
                end
            end
            assign q_o[g] = s2_r;
        end
    endgenerate
endmodule

// ---- dv/bsr_tap_properties.sv ----
module bsr_tap_properties (
    // clock, reset, test port
    input wire        core_clk_i, arst_n_i, tck_i, tdo_o, tdo_oe_o,
    // functional side and pins
    input wire        extest_o, core_chan_ctl_i, core_chan_ctl_oe_i,
    input wire        core_ack_i,
    input wire [15:0] core_tx_i, core_tx_oe_i, core_bus_i, core_bus_oe_i,
    input wire [15:0] pin_tx_o, pin_tx_oe_o, pin_bus_o, pin_bus_oe_o,
    input wire        control_channel_pin_o, control_channel_pin_oe_o,
    input wire        data_ack_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // port checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_tck_rise;
        $rose(tck_i);
    endsequence
    sequence s_tdo_hold;
        $stable(tdo_o) [*3];
    endsequence
    a_float_drives_low: assert property (!tdo_oe_o |-> !tdo_o)
        else $error("tdo not low while floating");
    a_pins_follow_core: assert property (!extest_o |->
        pin_tx_o == core_tx_i && pin_tx_oe_o == core_tx_oe_i &&
        pin_bus_o == core_bus_i && pin_bus_oe_o == core_bus_oe_i)
        else $error("pins differ from core outside extest");
    a_side_pins_follow: assert property (!extest_o |->
        control_channel_pin_o == core_chan_ctl_i &&
        data_ack_pin_o == core_ack_i &&
        control_channel_pin_oe_o == core_chan_ctl_oe_i)
        else $error("side pins differ from core outside extest");
    a_tdo_at_fall: assert property (
        $changed(tdo_o) |-> !$past(tck_i, 2))
        else $error("tdo moved away from a falling test clock");
    a_oe_at_fall: assert property (
        $changed(tdo_oe_o) |-> !$past(tck_i, 2))
        else $error("tdo enable moved off a falling edge");
    a_tdo_holds_high: assert property (s_tck_rise |=> s_tdo_hold)
        else $error("tdo moved during high test clock");
    a_extest_ignores: assert property (
        extest_o && $stable(extest_o) && $changed(core_tx_i)
        |-> $stable(pin_tx_o))
        else $error("extest pins followed core");
    a_oe_off_reset: assert property (
        $rose(arst_n_i) |-> !tdo_oe_o)
        else $error("tdo enabled out of reset");
endmodule

bind bsr_tap bsr_tap_properties i_props (.core_clk_i, .arst_n_i, .tck_i,
    .tdo_o, .tdo_oe_o, .extest_o, .core_chan_ctl_i, .core_chan_ctl_oe_i,
    .core_ack_i, .core_tx_i, .core_tx_oe_i, .core_bus_i, .core_bus_oe_i,
    .pin_tx_o, .pin_tx_oe_o, .pin_bus_o, .pin_bus_oe_o,
    .control_channel_pin_o, .control_channel_pin_oe_o, .data_ack_pin_o);

// ---- dv/bsr_jtag_host.sv ----
module bsr_jtag_host (
    output logic tck_o, tms_o, tdi_o, trst_n_o,
    input  wire  tdo_i, tdo_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tdo_s;
    // ========================================
    // test clock stands low outside scans; tms and tdi sit high, trst_n starts low
    initial begin
        {tck_o, tms_o, tdi_o, trst_n_o} = 4'b0110;
    end
    // inputs set a full low phase before the rise
    task automatic bit_clk(input logic m, input logic d);
        tms_o = m;
        tdi_o = d;
        #80 tck_o = 1;
        // floating tdo never matches
        #79 tdo_s = tdo_oe_i ? tdo_i : 1'bx;
        #1 tck_o = 0;
    endtask
    task automatic tap_reset;
        #200 trst_n_o = 1;
        #200;
        repeat (5) bit_clk(1, 1);
        bit_clk(0, 1);
    endtask
    // from idle through capture, n shifts, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        dout = '0;
        bit_clk(1, 1);
        if (ir) bit_clk(1, 1);
        bit_clk(0, 1);
        bit_clk(0, 1);
        for (int k = 0; k < n; k++) begin
            bit_clk(k == n - 1, din[k]);
            dout[k] = tdo_s;
        end
        bit_clk(1, 1);
        bit_clk(0, 1);
        tdi_o = 1;
    endtask
endmodule

// ---- dv/bsr_tap_tb.sv ----
module bsr_tap_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 0, arst_n_i = 0;
    logic        core_chan_ctl_i, core_chan_ctl_oe_i;
    logic        core_ack_i, output_drive_enable_pin_i;
    logic [15:0] core_tx_i, core_tx_oe_i, core_bus_i, core_bus_oe_i;
    logic [15:0] pin_bus_i, pin_rx_i;
    logic [17:0] pin_ctl_i;
    wire         tck, tms, tdi, trst_n, tdo_o, tdo_oe_o, extest_o;
    wire         control_channel_pin_o, control_channel_pin_oe_o;
    wire         data_ack_pin_o;
    wire  [15:0] pin_tx_o, pin_tx_oe_o, pin_bus_o, pin_bus_oe_o;
    int          failures = 0, tests_run = 0;
    logic [127:0] dout;
    localparam logic [127:0] PRE = 128'h0020_0040_0000_0000_0000_0000_003a_0003;
    bsr_tap i_dut (.core_clk_i, .arst_n_i, .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o, .tdo_oe_o, .core_tx_i,
        .core_tx_oe_i, .core_chan_ctl_i, .core_chan_ctl_oe_i, .core_ack_i,
        .core_bus_i, .core_bus_oe_i, .pin_bus_i, .output_drive_enable_pin_i,
        .pin_ctl_i, .pin_rx_i, .pin_tx_o, .pin_tx_oe_o, .control_channel_pin_o,
        .control_channel_pin_oe_o, .data_ack_pin_o, .pin_bus_o,
        .pin_bus_oe_o, .extest_o);
    bsr_jtag_host i_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
    // ========================================
    // scenarios
    initial forever #10 core_clk_i = ~core_clk_i;
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_bypass;
        i_host.scan(0, 8, 128'h00a5, dout);
        check(dout, 128'h004a);
        repeat (10) @(negedge core_clk_i);
        check({tdo_oe_o, tdo_o}, 2'b00);
    endtask
    task automatic t_sample;
        i_host.scan(1, 3, 128'h0002, dout);
        check(dout, 128'h0001);
        i_host.scan(0, 118, PRE, dout);
        check({dout[101], dout[86], dout[85], dout[73], dout[72], dout[68],
               dout[67], dout[25], dout[22], dout[16]}, 10'h3db);
        // two extra shifts expose the chain length, update image unchanged
        i_host.scan(0, 120, {PRE[117:0], 2'b10}, dout);
        check(dout[119:118], 2'b10);
        check({pin_tx_o, pin_tx_oe_o, extest_o},
              {core_tx_i, core_tx_oe_i, 1'b0});
    endtask
    task automatic t_codes;
        for (int c = 7; c >= 0; c--) begin
            i_host.scan(1, 3, 128'(c), dout);
            repeat (10) @(negedge core_clk_i);
            check(extest_o, c < 2);
        end
    endtask
    task automatic t_extest;
        check({pin_tx_oe_o[7], pin_tx_o[7], control_channel_pin_oe_o,
               control_channel_pin_o, data_ack_pin_o, pin_bus_oe_o[15],
               pin_bus_o[15], pin_tx_oe_o[15], pin_tx_o[15], pin_tx_oe_o[8],
               pin_tx_o[8]}, 11'h779);
        @(negedge core_clk_i) core_tx_i = 16'hffff;
        @(negedge core_clk_i);
        check({pin_tx_o[15], pin_tx_o[7], pin_tx_oe_o[6]}, 3'b010);
    endtask
    initial begin
        {core_tx_i, core_tx_oe_i, core_bus_i, core_bus_oe_i} = 64'hffff_0000;
        {core_chan_ctl_i, core_chan_ctl_oe_i, core_ack_i} = 3'b100;
        {pin_bus_i, pin_rx_i, pin_ctl_i} = {16'h8001, 16'h8001, 18'h2_1001};
        output_drive_enable_pin_i = 1;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i) arst_n_i = 1;
        i_host.tap_reset();
        t_bypass();
        t_sample();
        t_codes();
        t_extest();
        i_host.scan(1, 3, 128'h0006, dout);
        t_bypass();
        results();
    end
    // ample margin over roughly 60 us of scans
    initial begin
        #500us;
        failures++;
        results();
    end
endmodule
